// File: include/wrc_consts.vh
// Purpose: Constants of the watchdog and reset control block
// Assumes: Included by wrc_watchdog_reset.v only
// Notes: Offsets are APB byte addresses
`ifndef WRC_CONSTS_VH
`define WRC_CONSTS_VH
`define WRC_OFS_CAUSE 8'h00
`define WRC_OFS_OPT1 8'h04
`define WRC_OFS_OPT2 8'h08
`define WRC_OFS_STAT 8'h0C
`define WRC_CAUSE_POR 7
`define WRC_CAUSE_PIN 6
`define WRC_CAUSE_WDOG 5
`define WRC_CAUSE_ILLEGAL_OPCODE_DETECT 4
`define WRC_CAUSE_ILLEGAL_ADDRESS_DETECT 3
`define WRC_CAUSE_LVD 1
`define WRC_CAUSE_RST 8'h80
`define WRC_OPT1_TSEL_HI 7
`define WRC_OPT1_TSEL_LO 6
`define WRC_OPT1_RPE 0
`define WRC_OPT2_WCLK 7
`define WRC_OPT2_WMODE 6
`define WRC_TSEL_RST 2'h3
`define WRC_RPE_RST 1'b0
`define WRC_WCLK_RST 1'b0
`define WRC_WMODE_RST 1'b0
`define WRC_STAT_ARMED 24
`define WRC_STAT_W1 25
`define WRC_STAT_W2 26
`define WRC_SVC_FIRST 8'h55
`define WRC_SVC_SECOND 8'hAA
`define WRC_OVF_LPO_1 19'h0_0020
`define WRC_OVF_LPO_2 19'h0_0100
`define WRC_OVF_LPO_3 19'h0_0400
`define WRC_OVF_BUS_1 19'h0_2000
`define WRC_OVF_BUS_2 19'h1_0000
`define WRC_OVF_BUS_3 19'h4_0000
`define WRC_WIN_BUS_1 19'h0_1800
`define WRC_WIN_BUS_2 19'h0_C000
`define WRC_WIN_BUS_3 19'h3_0000
`define WRC_RST_HOLD 4'h8
`define WRC_VEC_HI 16'hFFFE
`define WRC_VEC_LO 16'hFFFF
`define WRC_STACK_INIT 16'h00FF
`endif

// File: design/wrc_watchdog_reset.v
// Purpose: Watchdog timer, reset cause recording and reset sequencing
// Assumes: APB3 slave, zero wait states; 1 kHz clock arrives as a pin
// Notes: Reset cause survives system reset; options return to their defaults (timeout select 3), counter and armed flag are cleared by it
`timescale 1ns/1ns
`default_nettype none
`include "wrc_consts.vh"

module wrc_watchdog_reset #(
  parameter [18:0] OVF_BUS_1 = `WRC_OVF_BUS_1,
  parameter [18:0] OVF_BUS_2 = `WRC_OVF_BUS_2,
  parameter [18:0] OVF_BUS_3 = `WRC_OVF_BUS_3,
  parameter [18:0] WIN_BUS_1 = `WRC_WIN_BUS_1,
  parameter [18:0] WIN_BUS_2 = `WRC_WIN_BUS_2,
  parameter [18:0] WIN_BUS_3 = `WRC_WIN_BUS_3,
  parameter [3:0] RST_HOLD = `WRC_RST_HOLD
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [7:0] paddr_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire reset_pin_b_i,
  input wire lpo_clk_i,
  input wire low_voltage_detect_i,
  input wire illegal_opcode_detect_i,
  input wire illegal_address_detect_i,
  input wire debug_force_reset_i,
  input wire debug_active_i,
  input wire stop_mode_i,
  input wire [7:0] vec_data_i,
  output wire [15:0] vec_addr_o,
  output wire vec_rd_o,
  output wire [15:0] pc_o,
  output wire pc_load_o,
  output wire [15:0] stack_pointer_o,
  output wire stack_pointer_load_o,
  output wire condition_code_register_imask_o,
  output wire sys_reset_o,
  output wire periph_disable_o,
  output wire pins_input_only_o,
  output wire pullups_off_o
);
  localparam [3:0] ST_HOLD = 4'h1;
  localparam [3:0] ST_VHI = 4'h2;
  localparam [3:0] ST_VLO = 4'h4;
  localparam [3:0] ST_RUN = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] hold_reg;
  reg [3:0] hold_next;
  reg [15:0] vec_addr_reg;
  reg [15:0] vec_addr_next;
  reg [15:0] pc_reg;
  reg [15:0] pc_next;
  reg pc_load_reg;
  reg [7:0] reset_cause_register_reg;
  reg [7:0] reset_cause_register_next;
  reg [1:0] timeout_select_reg;
  reg reset_pin_enable_reg;
  reg watchdog_clock_select_reg;
  reg window_mode_enable_reg;
  reg opt1_written_reg;
  reg opt2_written_reg;
  reg armed_reg;
  reg armed_next;
  reg [18:0] cnt_reg;
  reg [18:0] cnt_next;
  reg [31:0] prdata_reg;
  reg [31:0] rd_next;
  reg pin_s1_reg;
  reg pin_s2_reg;
  reg pin_s3_reg;
  reg pin_f_reg;
  reg lpo_s1_reg;
  reg lpo_s2_reg;
  reg lpo_s3_reg;
  reg lpo_f_reg;
  reg [18:0] lim;
  reg [18:0] win_open;
  reg ev_any;
  reg [7:0] ev_cause;

  wire in_reset = ~state_reg[3];
  wire acc = psel_i & penable_i;
  wire setup = psel_i & ~penable_i;
  wire mapped = (paddr_i == `WRC_OFS_CAUSE) | (paddr_i == `WRC_OFS_OPT1) |
                (paddr_i == `WRC_OFS_OPT2) | (paddr_i == `WRC_OFS_STAT);
  // Writes are dropped while the system is held in reset
  wire wr_ok = acc & pwrite_i & ~in_reset;
  wire wr_cause = wr_ok & (paddr_i == `WRC_OFS_CAUSE);
  wire wr_opt1 = wr_ok & (paddr_i == `WRC_OFS_OPT1) & ~opt1_written_reg;
  wire wr_opt2 = wr_ok & (paddr_i == `WRC_OFS_OPT2) & ~opt2_written_reg;
  wire is_first = (pwdata_i[7:0] == `WRC_SVC_FIRST);
  wire is_second = (pwdata_i[7:0] == `WRC_SVC_SECOND);

  // Both slow inputs cross in via three flops; level moves when 2nd and 3rd agree
  wire pin_agree = (pin_s2_reg == pin_s3_reg);
  wire lpo_agree = (lpo_s2_reg == lpo_s3_reg);
  wire lpo_tick = lpo_agree & lpo_s2_reg & ~lpo_f_reg;

  wire wd_en = (timeout_select_reg != 2'h0);
  wire freeze = debug_active_i | stop_mode_i;
  wire bus_sel = watchdog_clock_select_reg;
  wire inc = wd_en & ~freeze & (bus_sel | lpo_tick);
  wire lpo_clear = ~bus_sel & freeze;
  wire timeout = inc & (cnt_reg == lim - 19'h0_0001);
  // Window check applies only on the bus clock
  wire early = wr_cause & wd_en & bus_sel & window_mode_enable_reg &
               (cnt_reg < win_open);
  wire bad_val = wr_cause & ~is_first & ~is_second;
  wire restart = wr_cause & is_second & armed_reg & ~early;
  wire pin_ev = reset_pin_enable_reg & ~pin_f_reg;
  wire wd_ev = timeout | bad_val | early;

  always @* begin
    case (timeout_select_reg)
      2'h1: begin
        lim = bus_sel ? OVF_BUS_1 : `WRC_OVF_LPO_1;
        win_open = WIN_BUS_1;
      end
      2'h2: begin
        lim = bus_sel ? OVF_BUS_2 : `WRC_OVF_LPO_2;
        win_open = WIN_BUS_2;
      end
      2'h3: begin
        lim = bus_sel ? OVF_BUS_3 : `WRC_OVF_LPO_3;
        win_open = WIN_BUS_3;
      end
      default: begin
        lim = OVF_BUS_3;
        win_open = WIN_BUS_3;
      end
    endcase
  end

  // At most one cause per reset (none for debug); simultaneous sources resolved by fixed priority
  always @* begin
    ev_any = 1'b1;
    ev_cause = 8'h00;
    if (pin_ev) begin
      ev_cause[`WRC_CAUSE_PIN] = 1'b1;
    end else if (low_voltage_detect_i) begin
      ev_cause[`WRC_CAUSE_LVD] = 1'b1;
    end else if (wd_ev) begin
      ev_cause[`WRC_CAUSE_WDOG] = 1'b1;
    end else if (illegal_opcode_detect_i) begin
      ev_cause[`WRC_CAUSE_ILLEGAL_OPCODE_DETECT] = 1'b1;
    end else if (illegal_address_detect_i) begin
      ev_cause[`WRC_CAUSE_ILLEGAL_ADDRESS_DETECT] = 1'b1;
    end else if (debug_force_reset_i) begin
      ev_cause = 8'h00;
    end else begin
      ev_any = 1'b0;
    end
  end

  always @* begin
    state_next = state_reg;
    hold_next = hold_reg;
    vec_addr_next = vec_addr_reg;
    pc_next = pc_reg;
    reset_cause_register_next = reset_cause_register_reg;
    if (ev_any) begin
      state_next = ST_HOLD;
      hold_next = 4'h0;
      vec_addr_next = `WRC_VEC_HI;
      reset_cause_register_next = ev_cause;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          if (hold_reg == RST_HOLD - 4'h1) begin
            state_next = ST_VHI;
          end else begin
            hold_next = hold_reg + 4'h1;
          end
        end
        ST_VHI: begin
          pc_next = {vec_data_i, pc_reg[7:0]};
          vec_addr_next = `WRC_VEC_LO;
          state_next = ST_VLO;
        end
        ST_VLO: begin
          pc_next = {pc_reg[15:8], vec_data_i};
          vec_addr_next = `WRC_VEC_HI;
          state_next = ST_RUN;
        end
        ST_RUN: begin
          state_next = ST_RUN;
        end
        default: begin
          state_next = ST_HOLD;
          hold_next = 4'h0;
        end
      endcase
    end
  end

  always @* begin
    armed_next = armed_reg;
    if (in_reset | restart) begin
      armed_next = 1'b0;
    end else if (wr_cause) begin
      armed_next = is_first & ~early;
    end
  end

  always @* begin
    cnt_next = cnt_reg;
    // Clearing covers reset, service, option lock, disable and, on the 1 kHz clock only, stop or debug
    if (in_reset | restart | wr_opt1 | wr_opt2 | lpo_clear | ~wd_en) begin
      cnt_next = 19'h0_0000;
    end else if (inc) begin
      cnt_next = cnt_reg + 19'h0_0001;
    end
  end

  always @* begin
    rd_next = 32'h0000_0000;
    case (paddr_i)
      `WRC_OFS_CAUSE: begin
        rd_next[7:0] = reset_cause_register_reg;
      end
      `WRC_OFS_OPT1: begin
        rd_next[`WRC_OPT1_TSEL_HI:`WRC_OPT1_TSEL_LO] = timeout_select_reg;
        rd_next[`WRC_OPT1_RPE] = reset_pin_enable_reg;
      end
      `WRC_OFS_OPT2: begin
        rd_next[`WRC_OPT2_WCLK] = watchdog_clock_select_reg;
        rd_next[`WRC_OPT2_WMODE] = window_mode_enable_reg;
      end
      `WRC_OFS_STAT: begin
        rd_next[18:0] = cnt_reg;
        rd_next[`WRC_STAT_ARMED] = armed_reg;
        rd_next[`WRC_STAT_W1] = opt1_written_reg;
        rd_next[`WRC_STAT_W2] = opt2_written_reg;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
      pin_s3_reg <= 1'b1;
      pin_f_reg <= 1'b1;
      lpo_s1_reg <= 1'b0;
      lpo_s2_reg <= 1'b0;
      lpo_s3_reg <= 1'b0;
      lpo_f_reg <= 1'b0;
    end else begin
      pin_s1_reg <= reset_pin_b_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_agree) begin
        pin_f_reg <= pin_s2_reg;
      end
      lpo_s1_reg <= lpo_clk_i;
      lpo_s2_reg <= lpo_s1_reg;
      lpo_s3_reg <= lpo_s2_reg;
      if (lpo_agree) begin
        lpo_f_reg <= lpo_s2_reg;
      end
    end
  end

  // Power-on is the only cause a constant reset value may carry
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_HOLD;
      hold_reg <= 4'h0;
      vec_addr_reg <= `WRC_VEC_HI;
      pc_reg <= 16'h0000;
      pc_load_reg <= 1'b0;
      reset_cause_register_reg <= `WRC_CAUSE_RST;
      prdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      vec_addr_reg <= vec_addr_next;
      pc_reg <= pc_next;
      pc_load_reg <= state_reg[2] & ~ev_any;
      reset_cause_register_reg <= reset_cause_register_next;
      if (setup) begin
        prdata_reg <= rd_next;
      end
    end
  end

  // Options fall back to defaults on every system reset
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timeout_select_reg <= `WRC_TSEL_RST;
      reset_pin_enable_reg <= `WRC_RPE_RST;
      watchdog_clock_select_reg <= `WRC_WCLK_RST;
      window_mode_enable_reg <= `WRC_WMODE_RST;
      opt1_written_reg <= 1'b0;
      opt2_written_reg <= 1'b0;
      armed_reg <= 1'b0;
      cnt_reg <= 19'h0_0000;
    end else begin
      armed_reg <= armed_next;
      cnt_reg <= cnt_next;
      if (in_reset) begin
        timeout_select_reg <= `WRC_TSEL_RST;
        reset_pin_enable_reg <= `WRC_RPE_RST;
        watchdog_clock_select_reg <= `WRC_WCLK_RST;
        window_mode_enable_reg <= `WRC_WMODE_RST;
        opt1_written_reg <= 1'b0;
        opt2_written_reg <= 1'b0;
      end else begin
        if (wr_opt1) begin
          timeout_select_reg <= pwdata_i[`WRC_OPT1_TSEL_HI:`WRC_OPT1_TSEL_LO];
          reset_pin_enable_reg <= pwdata_i[`WRC_OPT1_RPE];
          opt1_written_reg <= 1'b1;
        end
        if (wr_opt2) begin
          watchdog_clock_select_reg <= pwdata_i[`WRC_OPT2_WCLK];
          window_mode_enable_reg <= pwdata_i[`WRC_OPT2_WMODE];
          opt2_written_reg <= 1'b1;
        end
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign vec_addr_o = vec_addr_reg;
  assign vec_rd_o = state_reg[1] | state_reg[2];
  assign pc_o = pc_reg;
  assign pc_load_o = pc_load_reg;
  assign stack_pointer_o = `WRC_STACK_INIT;
  assign stack_pointer_load_o = pc_load_reg;
  assign condition_code_register_imask_o = in_reset;
  assign sys_reset_o = in_reset;
  assign periph_disable_o = in_reset;
  assign pins_input_only_o = in_reset;
  assign pullups_off_o = in_reset;
endmodule // wrc_watchdog_reset
`default_nettype wire

// File: testbench/wrc_watchdog_reset_asserts.sv
// Purpose: Concurrent checks on the watchdog and reset control ports
// Assumes: One clock domain, asynchronous active low reset
// Notes: Attached to every instance of the block by bind
`timescale 1ns/1ns
`default_nettype none
module wrc_watchdog_reset_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic low_voltage_detect_i,
  input wire logic illegal_opcode_detect_i,
  input wire logic illegal_address_detect_i,
  input wire logic [7:0] vec_data_i,
  input wire logic [15:0] vec_addr_o,
  input wire logic vec_rd_o,
  input wire logic [15:0] pc_o,
  input wire logic pc_load_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic stack_pointer_load_o,
  input wire logic condition_code_register_imask_o,
  input wire logic sys_reset_o,
  input wire logic periph_disable_o,
  input wire logic pins_input_only_o,
  input wire logic pullups_off_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire cause_wr = psel_i && penable_i && pwrite_i && paddr_i == 8'h00;
  wire cause_rd = psel_i && penable_i && !pwrite_i && paddr_i == 8'h00;
  imask_set_a: assert property (sys_reset_o |-> condition_code_register_imask_o)
    else $error("interrupt mask clear during reset");
  pins_safe_a: assert property (sys_reset_o |-> periph_disable_o && pins_input_only_o && pullups_off_o)
    else $error("peripherals or pins active during reset");
  stack_init_a: assert property (stack_pointer_load_o |-> stack_pointer_o == 16'h00FF)
    else $error("stack pointer not 00FF at load");
  vector_fetch_a: assert property ((vec_rd_o && vec_addr_o == 16'hFFFE) ##1 (vec_rd_o && vec_addr_o == 16'hFFFF) |=> pc_load_o && pc_o == {$past(vec_data_i, 2), $past(vec_data_i)})
    else $error("program counter not loaded from vector pair");
  run_start_a: assert property ($fell(sys_reset_o) |-> pc_load_o && $past(vec_rd_o))
    else $error("execution started without vector fetch");
  bad_value_a: assert property (cause_wr && !sys_reset_o && pwdata_i[7:0] != 8'h55 && pwdata_i[7:0] != 8'hAA |=> sys_reset_o)
    else $error("wrong service value did not reset");
  event_reset_a: assert property (low_voltage_detect_i || illegal_opcode_detect_i || illegal_address_detect_i |=> sys_reset_o)
    else $error("reset source did not reset");
  cause_single_a: assert property (cause_rd |-> $onehot0(prdata_o))
    else $error("more than one cause bit set");
  cover property (pc_load_o);
  cover property (cause_wr && pwdata_i[7:0] == 8'hAA);
  cover property (cause_rd && prdata_o[5]);
endmodule // wrc_watchdog_reset_asserts
bind wrc_watchdog_reset wrc_watchdog_reset_asserts i_wrc_watchdog_reset_asserts (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .low_voltage_detect_i(low_voltage_detect_i), .illegal_opcode_detect_i(illegal_opcode_detect_i),
  .illegal_address_detect_i(illegal_address_detect_i), .vec_data_i(vec_data_i),
  .vec_addr_o(vec_addr_o), .vec_rd_o(vec_rd_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
  .stack_pointer_o(stack_pointer_o), .stack_pointer_load_o(stack_pointer_load_o),
  .condition_code_register_imask_o(condition_code_register_imask_o),
  .sys_reset_o(sys_reset_o), .periph_disable_o(periph_disable_o),
  .pins_input_only_o(pins_input_only_o), .pullups_off_o(pullups_off_o));
`default_nettype wire

// File: testbench/wrc_watchdog_reset_bench.sv
// Purpose: Self-checking bench for the watchdog and reset control block
// Assumes: Setting-1 bus-clock counts shrunk to 64 overflow and 48 window open
// Notes: Reads are queued by the driver and matched by a monitor
`timescale 1ns/1ns
`default_nettype none
module wrc_watchdog_reset_bench;
  logic clk, rst_b, psel, pen, pwr, pin_b, lpo, low_voltage_detect, illegal_opcode_detect, illegal_address_detect, dbg, stp, dact;
  logic [7:0] paddr;
  logic [31:0] pwdata, d;
  logic [31:0] rnd = 32'h8761_a606;
  logic [7:0] bad [3] = '{8'h00, 8'h56, 8'hFF};
  logic [7:0] cz [4] = '{8'h02, 8'h10, 8'h08, 8'h00};
  wire [31:0] prdata;
  wire pready, pslverr, vrd, pcl, spl, imask, srst, pdis, pinp, puoff;
  wire [15:0] vaddr, pc, sp;
  // Vector bytes answer combinationally, as the fetch needs
  wire [7:0] vdata = (vaddr == 16'hFFFE) ? 8'h5A : 8'hC3;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [32:0] expq[$];
  wrc_watchdog_reset #(.OVF_BUS_1(19'h0_0040), .WIN_BUS_1(19'h0_0030)) i_wrc_watchdog_reset (
    .clk_i(clk), .rst_b_i(rst_b), .paddr_i(paddr), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .reset_pin_b_i(pin_b), .lpo_clk_i(lpo), .low_voltage_detect_i(low_voltage_detect),
    .illegal_opcode_detect_i(illegal_opcode_detect), .illegal_address_detect_i(illegal_address_detect), .debug_force_reset_i(dbg),
    .debug_active_i(dact), .stop_mode_i(stp), .vec_data_i(vdata), .vec_addr_o(vaddr),
    .vec_rd_o(vrd), .pc_o(pc), .pc_load_o(pcl), .stack_pointer_o(sp),
    .stack_pointer_load_o(spl), .condition_code_register_imask_o(imask),
    .sys_reset_o(srst), .periph_disable_o(pdis), .pins_input_only_o(pinp),
    .pullups_off_o(puoff));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rng();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, pen} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(a, 1'b0, 32'h0000_0000);
  endtask
  // Random upper bits must be ignored by the service decode
  task automatic wr_cause(input logic [7:0] v);
    d = rng();
    apb(8'h00, 1'b1, {d[31:8], v});
  endtask
  task automatic cfg(input logic [7:0] o1, input logic [7:0] o2);
    apb(8'h08, 1'b1, {24'h00_0000, o2});
    apb(8'h04, 1'b1, {24'h00_0000, o1});
  endtask
  task automatic watch(input int b, input logic want);
    int n;
    n = 0;
    while (srst !== 1'b1 && n < b) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(srst, want, "reset state");
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (srst !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({srst, pcl, pc}, {2'b01, 16'h5AC3}, "vector load");
    check(sp, 16'h00FF, "stack pointer");
  endtask
  always @(posedge clk) begin
    if (psel && pen && pready && !pwr) begin
      if (expq.size() == 0)
        check(0, 1, "unexpected read");
      else
        check({pslverr, prdata}, expq.pop_front(), "read data");
    end
  end
  // Fast stand-in for the 1 kHz clock keeps slow-clock tests short, plus the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lpo <= cyc[3];
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {rst_b, psel, pen, pwr, paddr, pwdata} = '0;
    {pin_b, low_voltage_detect, illegal_opcode_detect, illegal_address_detect, dbg, stp, dact} = 7'b100_0000;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_run();
    rd(8'h00, 33'h80);
    rd(8'h04, 33'hC0);
    rd(8'h08, 33'h00);
    rd(8'h10, 33'h1_0000_0000);
    $display("Test defaults done");
    for (int i = 0; i < 3; i++) begin
      wr_cause(bad[i]);
      watch(3, 1'b1);
      wait_run();
      rd(8'h00, 33'h20);
    end
    wr_cause(8'h55);
    rd(8'h00, 33'h20);
    $display("Test wrong value done");
    cfg(8'h40, 8'h80);
    watch(40, 1'b0);
    wr_cause(8'h55);
    wr_cause(8'hAA);
    apb(8'h04, 1'b1, 32'h0000_0000);
    rd(8'h04, 33'h40);
    watch(40, 1'b0);
    watch(30, 1'b1);
    wait_run();
    $display("Test service done");
    cfg(8'h40, 8'h80);
    watch(40, 1'b0);
    wr_cause(8'hAA);
    watch(30, 1'b1);
    wait_run();
    $display("Test lone second write done");
    cfg(8'h40, 8'hC0);
    watch(10, 1'b0);
    wr_cause(8'h55);
    watch(3, 1'b1);
    wait_run();
    cfg(8'h40, 8'hC0);
    watch(50, 1'b0);
    wr_cause(8'h55);
    wr_cause(8'hAA);
    watch(40, 1'b0);
    watch(40, 1'b1);
    wait_run();
    $display("Test window done");
    cfg(8'hC0, 8'h40);
    wr_cause(8'h55);
    wr_cause(8'hAA);
    watch(20, 1'b0);
    $display("Test slow clock window done");
    for (int i = 0; i < 4; i++) begin
      {low_voltage_detect, illegal_opcode_detect, illegal_address_detect, dbg} <= 4'b1000 >> i;
      @(posedge clk);
      {low_voltage_detect, illegal_opcode_detect, illegal_address_detect, dbg} <= 4'b0000;
      watch(3, 1'b1);
      wait_run();
      rd(8'h00, {25'h000_0000, cz[i]});
    end
    $display("Test reset sources done");
    cfg(8'h00, 8'h80);
    pin_b <= 1'b0;
    watch(300, 1'b0);
    pin_b <= 1'b1;
    rd(8'h0C, 33'h0_0600_0000);
    wr_cause(8'h12);
    watch(3, 1'b1);
    wait_run();
    cfg(8'h01, 8'h80);
    pin_b <= 1'b0;
    repeat (5) @(posedge clk);
    pin_b <= 1'b1;
    watch(10, 1'b1);
    wait_run();
    rd(8'h00, 33'h40);
    $display("Test reset pin done");
    cfg(8'h40, 8'h80);
    stp <= 1'b1;
    watch(100, 1'b0);
    {stp, dact} <= 2'b01;
    watch(100, 1'b0);
    dact <= 1'b0;
    watch(70, 1'b1);
    wait_run();
    $display("Test stop hold done");
    cfg(8'h40, 8'h00);
    watch(400, 1'b0);
    stp <= 1'b1;
    watch(20, 1'b0);
    stp <= 1'b0;
    watch(490, 1'b0);
    watch(30, 1'b1);
    wait_run();
    $display("Test slow clock timeout done");
    print_verdict();
  end
endmodule // wrc_watchdog_reset_bench
`default_nettype wire
